// *** verilog/cfg_consts.svh ***
// Constants for the main configuration register bank: offsets, fields, resets, counts.
// Assumes it is included by its bare name in every file that needs it.
`ifndef CFG_CONSTS_SVH
`define CFG_CONSTS_SVH

`define MAIN_CFG_ADDR        8'h04
`define MAIN_CFG_RESET       32'h0000_0006
`define THRESH_HI            11
`define THRESH_LO            10
`define TX_CT_BIT            9
`define RX_CT_BIT            8
`define STAMP_EN_BIT         7
`define STAMP_SEL_BIT        6
`define CREDIT_W             8
`define THR_CODE0            8'h01
`define THR_CODE1            8'h04
`define THR_CODE2            8'h08
`define THR_CODE3            8'h10
`define STAMP_BYTES_32       4'h4
`define STAMP_BYTES_64       4'h8
`define CT_MIN_BYTES         12'h001

`endif

// *** verilog/cfg_pkg.sv ***
// Types shared by the configuration bank and its frame start gates.
// Assumes cfg_consts.svh is on the include path.
`include "cfg_consts.svh"
package cfg_pkg;

    typedef struct packed {
        logic [1:0] tx_credit_irq_threshold;
        logic       tx_cut_through_en;
        logic       rx_cut_through_en;
        logic       frame_stamp_en;
        logic       frame_stamp_size_sel;
    } cfg_fields_t;

    typedef struct packed {
        logic       rx_en;
        logic       tx_en;
        logic       size_64;
        logic [3:0] len_bytes;
    } stamp_ctrl_t;

    typedef enum logic [1:0] {
        GATE_IDLE,
        GATE_WAIT,
        GATE_FWD
    } gate_state_t;

    typedef struct packed {
        gate_state_t st;
        logic        start;
    } gate_regs_t;

    typedef struct packed {
        cfg_fields_t cfg;
        logic        credit_irq;
        stamp_ctrl_t stamp;
        logic [31:0] rdata;
        logic        rvalid;
    } bank_regs_t;

endpackage

// *** verilog/frame_start_gate.sv ***
// Decides when a buffered frame may start forwarding: early in cut-through, else once complete.
// Assumes the frame buffer reports stored bytes and completion synchronously to sys_clk.
`include "cfg_consts.svh"
module frame_start_gate
    import cfg_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        cut_through,
    input  wire logic        frame_avail,
    input  wire logic [11:0] stored_bytes,
    input  wire logic        frame_complete,
    input  wire logic        fwd_done,
    output logic             fwd_start
);

    gate_regs_t q;
    gate_regs_t d;

    always_comb begin
        d = q;
        case (q.st)
            GATE_IDLE: begin
                d.start = 1'b0;
                if (frame_avail) begin
                    d.st = GATE_WAIT;
                end
            end
            GATE_WAIT: begin
                // Cut-through starts on the first bytes, store-and-forward waits for the end
                if ((cut_through && stored_bytes >= `CT_MIN_BYTES) || frame_complete) begin
                    d.st    = GATE_FWD;
                    d.start = 1'b1;
                end
            end
            GATE_FWD: begin
                if (fwd_done) begin
                    d.st    = GATE_IDLE;
                    d.start = 1'b0;
                end
            end
            default: begin
                d.st    = GATE_IDLE;
                d.start = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: GATE_IDLE, start: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign fwd_start = q.start;

endmodule

// *** verilog/main_cfg_bank.sv ***
// Main configuration register: credit threshold interrupt, cut-through enables, frame stamping.
// Assumes the serial front end presents decoded register accesses synchronous to sys_clk.
// Assumes the transmit and receive frame buffers report their fill state synchronous to sys_clk.
// Assumes chunk_protocol is a static strap, settled before reset is released.
`include "cfg_consts.svh"
module main_cfg_bank
    import cfg_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic                  ce,
    input  wire logic                  chunk_protocol,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    output logic [31:0]                reg_rdata,
    output logic                       reg_rvalid,
    input  wire logic [`CREDIT_W-1:0]  tx_free_credits,
    output logic                       tx_credit_irq,
    input  wire logic                  tx_frame_avail,
    input  wire logic [11:0]           tx_stored_bytes,
    input  wire logic                  tx_frame_complete,
    input  wire logic                  tx_fwd_done,
    output logic                       tx_fwd_start,
    input  wire logic                  rx_frame_avail,
    input  wire logic [11:0]           rx_stored_bytes,
    input  wire logic                  rx_frame_complete,
    input  wire logic                  rx_fwd_done,
    output logic                       rx_fwd_start,
    output logic                       stamp_rx_en,
    output logic                       stamp_tx_en,
    output logic                       stamp_size_64,
    output logic [3:0]                 stamp_len_bytes,
    output logic [31:0]                main_configuration
);

    logic [1:0]  rst_pipe_q;
    logic        rst_n;
    bank_regs_t  q;
    bank_regs_t  d;
    logic        rx_ct_eff;
    logic [31:0] cfg_word;

    // True when an access targets the main configuration register
    function automatic logic cfg_hit(input logic [7:0] addr);
        cfg_hit = (addr == `MAIN_CFG_ADDR);
    endfunction

    // Threshold code to credit count
    function automatic logic [`CREDIT_W-1:0] credit_level(input logic [1:0] code);
        case (code)
            2'h0: begin
                credit_level = `THR_CODE0;
            end
            2'h1: begin
                credit_level = `THR_CODE1;
            end
            2'h2: begin
                credit_level = `THR_CODE2;
            end
            default: begin
                credit_level = `THR_CODE3;
            end
        endcase
    endfunction

    // Space condition; under generic serial the threshold field is ignored and any credit counts
    function automatic logic credit_ok(input logic [`CREDIT_W-1:0] credits, input logic [1:0] code,
                                       input logic chunk);
        logic [`CREDIT_W-1:0] need;
        if (chunk) begin
            need = credit_level(code);
        end else begin
            need = `THR_CODE0;
        end
        credit_ok = (credits >= need);
    endfunction

    // Fields taken from a host write; bits outside the six writable ones are dropped here
    function automatic cfg_fields_t cfg_update(input logic [31:0] w);
        cfg_fields_t c;
        c.tx_credit_irq_threshold = w[`THRESH_HI:`THRESH_LO];
        c.tx_cut_through_en       = w[`TX_CT_BIT];
        c.rx_cut_through_en       = w[`RX_CT_BIT];
        c.frame_stamp_en          = w[`STAMP_EN_BIT];
        c.frame_stamp_size_sel    = w[`STAMP_SEL_BIT];
        cfg_update = c;
    endfunction

    // Stamp controls; size and length are forced off while stamping is disabled
    function automatic stamp_ctrl_t stamp_decode(input cfg_fields_t c);
        stamp_ctrl_t s;
        s.rx_en   = c.frame_stamp_en;
        s.tx_en   = c.frame_stamp_en;
        s.size_64 = c.frame_stamp_en & c.frame_stamp_size_sel;
        case ({c.frame_stamp_en, c.frame_stamp_size_sel})
            2'b10: begin
                s.len_bytes = `STAMP_BYTES_32;
            end
            2'b11: begin
                s.len_bytes = `STAMP_BYTES_64;
            end
            default: begin
                s.len_bytes = 4'h0;
            end
        endcase
        stamp_decode = s;
    endfunction

    // Read data: the register image for the mapped address, zero elsewhere
    function automatic logic [31:0] read_word(input logic [7:0] addr, input logic [31:0] image);
        if (cfg_hit(addr)) begin
            read_word = image;
        end else begin
            read_word = 32'h0000_0000;
        end
    endfunction

    // Assemble the register image from the held fields
    function automatic logic [31:0] cfg_image(input cfg_fields_t c);
        logic [31:0] v;
        v = `MAIN_CFG_RESET;
        v[`THRESH_HI:`THRESH_LO] = c.tx_credit_irq_threshold;
        v[`TX_CT_BIT]            = c.tx_cut_through_en;
        v[`RX_CT_BIT]            = c.rx_cut_through_en;
        v[`STAMP_EN_BIT]         = c.frame_stamp_en;
        v[`STAMP_SEL_BIT]        = c.frame_stamp_size_sel;
        cfg_image = v;
    endfunction

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_q[1];

    always_comb begin
        d        = q;
        d.rvalid = 1'b0;
        // Only the mapped address updates the fields
        if (reg_wr && cfg_hit(reg_addr)) begin
            d.cfg = cfg_update(reg_wdata);
        end
        // A read that meets a write in the same cycle returns the image from before it
        if (reg_rd) begin
            d.rvalid = 1'b1;
            d.rdata  = read_word(reg_addr, cfg_word);
        end
        // Recomputed every cycle from live credits and the held threshold
        d.credit_irq = credit_ok(tx_free_credits, q.cfg.tx_credit_irq_threshold, chunk_protocol);
        d.stamp      = stamp_decode(q.cfg);
    end

    // Low ce freezes fields and outputs together; reset does not wait for it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // Receive cut-through is meaningless off the chunk protocol
    assign rx_ct_eff = q.cfg.rx_cut_through_en & chunk_protocol;

    // Host-to-network start gate
    frame_start_gate tx_gate (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .ce             (ce),
        .cut_through    (q.cfg.tx_cut_through_en),
        .frame_avail    (tx_frame_avail),
        .stored_bytes   (tx_stored_bytes),
        .frame_complete (tx_frame_complete),
        .fwd_done       (tx_fwd_done),
        .fwd_start      (tx_fwd_start)
    );

    // Network-to-host start gate
    frame_start_gate rx_gate (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .ce             (ce),
        .cut_through    (rx_ct_eff),
        .frame_avail    (rx_frame_avail),
        .stored_bytes   (rx_stored_bytes),
        .frame_complete (rx_frame_complete),
        .fwd_done       (rx_fwd_done),
        .fwd_start      (rx_fwd_start)
    );

    // Registered outputs
    assign reg_rdata          = q.rdata;
    assign reg_rvalid         = q.rvalid;
    assign tx_credit_irq      = q.credit_irq;
    assign stamp_rx_en        = q.stamp.rx_en;
    assign stamp_tx_en        = q.stamp.tx_en;
    assign stamp_size_64      = q.stamp.size_64;
    assign stamp_len_bytes    = q.stamp.len_bytes;
    assign cfg_word           = cfg_image(q.cfg);
    assign main_configuration = cfg_word;

endmodule

// *** testbench/main_cfg_bank_assertions.sv ***
// Port checks for main_cfg_bank: bus, credit interrupt, stamps, frame start.
// Assumes it is bound into main_cfg_bank; one clock, nrst as reset.
module main_cfg_bank_assertions (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        ce,
    input wire logic        chunk_protocol,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic [7:0]  tx_free_credits,
    input wire logic        tx_credit_irq,
    input wire logic        tx_frame_complete,
    input wire logic        tx_fwd_start,
    input wire logic        stamp_rx_en,
    input wire logic        stamp_tx_en,
    input wire logic        stamp_size_64,
    input wire logic [3:0]  stamp_len_bytes,
    input wire logic [31:0] main_configuration
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] up_q;
    // Edges since reset release; checks wait out the reset synchroniser
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    function automatic logic [7:0] lvl(input logic [1:0] c, input logic k);
        return (!k || c == 2'h0) ? 8'h01 : c == 2'h1 ? 8'h04 : c == 2'h2 ? 8'h08 : 8'h10;
    endfunction
    sequence s_rd;
        ce && reg_rd;
    endsequence
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_irq_level: assert property (up_q == 3'h7 && $past(ce) |-> tx_credit_irq ==
        ($past(tx_free_credits) >= lvl($past(main_configuration[11:10]), $past(chunk_protocol)))) else $error("irq");
    a_write_lands: assert property (up_q == 3'h7 && ce && reg_wr && reg_addr == 8'h04 |=>
        main_configuration[11:6] == $past(reg_wdata[11:6])) else $error("write");
    a_fixed_bits: assert property (main_configuration[31:12] == 20'h0 && main_configuration[5:0] == 6'h06)
        else $error("fixed bits");
    a_read_data: assert property (up_q == 3'h7 ##0 s_rd |=> reg_rvalid &&
        reg_rdata == ($past(reg_addr) == 8'h04 ? $past(main_configuration) : 32'h0)) else $error("read");
    a_rvalid_cause: assert property (reg_rvalid && $past(ce) |-> $past(reg_rd)) else $error("rvalid");
    a_stamp_enable: assert property (up_q == 3'h7 && $past(ce) |->
        stamp_rx_en == $past(main_configuration[7])) else $error("stamp enable");
    a_stamp_size: assert property (up_q == 3'h7 && $past(ce) |-> stamp_len_bytes ==
        ($past(main_configuration[7]) ? ($past(main_configuration[6]) ? 4'h8 : 4'h4) : 4'h0)) else $error("size");
    a_stamp_format: assert property (up_q == 3'h7 && $past(ce) |->
        stamp_tx_en == $past(main_configuration[7]) &&
        stamp_size_64 == ($past(main_configuration[7]) && $past(main_configuration[6]))) else $error("stamp format");
    a_start_cause: assert property (up_q == 3'h7 && $rose(tx_fwd_start) |->
        $past(tx_frame_complete || main_configuration[9])) else $error("start");
endmodule

bind main_cfg_bank main_cfg_bank_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .chunk_protocol(chunk_protocol), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tx_free_credits(tx_free_credits),
    .tx_credit_irq(tx_credit_irq), .tx_frame_complete(tx_frame_complete), .tx_fwd_start(tx_fwd_start),
    .stamp_rx_en(stamp_rx_en), .stamp_tx_en(stamp_tx_en), .stamp_size_64(stamp_size_64),
    .stamp_len_bytes(stamp_len_bytes), .main_configuration(main_configuration));

// *** testbench/host_model.sv ***
// Host side model: single-cycle register writes and reads.
// Assumes the bench calls acc just after a rising edge.
module host_model (
    input  wire logic sys_clk,
    output logic      reg_wr,
    output logic      reg_rd,
    output logic [7:0]  reg_addr,
    output logic [31:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) #1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge sys_clk) #1;
        // Address and data no longer valid: show the inverse
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for main_cfg_bank with a host model on the register side.
// Assumes the design, checker and host model are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic c; logic [31:0] w; logic [7:0] cr; logic irq; logic [3:0] len;} row_t;
    logic sys_clk, nrst, ce, chunk;
    logic [7:0] cred;
    logic [1:0] avail, comp, done;
    logic [11:0] stored;
    wire reg_wr, reg_rd, reg_rvalid, irq;
    wire [1:0] start;
    wire [7:0] reg_addr;
    wire [31:0] reg_wdata, reg_rdata, cfg;
    wire [3:0] len;
    wire srx, stx, s64;
    int failures, n_checks;
    row_t rows [10] = '{
        '{1'b1, 32'hffff_f03f, 8'h01, 1'b1, 4'h0}, '{1'b1, 32'h0000_0000, 8'h00, 1'b0, 4'h0},
        '{1'b1, 32'h0000_0480, 8'h04, 1'b1, 4'h4}, '{1'b1, 32'h0000_04c0, 8'h03, 1'b0, 4'h8},
        '{1'b1, 32'h0000_0800, 8'h08, 1'b1, 4'h0}, '{1'b1, 32'h0000_0840, 8'h07, 1'b0, 4'h0},
        '{1'b1, 32'h0000_0c00, 8'h10, 1'b1, 4'h0}, '{1'b1, 32'h0000_0c00, 8'h0f, 1'b0, 4'h0},
        '{1'b0, 32'h0000_0c00, 8'h01, 1'b1, 4'h0}, '{1'b0, 32'h0000_0c80, 8'h00, 1'b0, 4'h4}};
    host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    main_cfg_bank dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .chunk_protocol(chunk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .tx_free_credits(cred), .tx_credit_irq(irq), .tx_frame_avail(avail[0]), .tx_stored_bytes(stored),
        .tx_frame_complete(comp[0]), .tx_fwd_done(done[0]), .tx_fwd_start(start[0]), .rx_frame_avail(avail[1]),
        .rx_stored_bytes(stored), .rx_frame_complete(comp[1]), .rx_fwd_done(done[1]), .rx_fwd_start(start[1]),
        .stamp_rx_en(srx), .stamp_tx_en(stx), .stamp_size_64(s64), .stamp_len_bytes(len), .main_configuration(cfg));
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic summarize;
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rst;
        nrst = 1'b0;
        #1 chk(cfg === 32'h6 && irq === 1'b0 && reg_rvalid === 1'b0 && len === 4'h0 && start === 2'b00, "reset");
        repeat (10) @(posedge sys_clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic wt(input int s, input logic lvl);
        for (int k = 0; k < 8 && start[s] !== lvl; k++) @(posedge sys_clk) #1;
        chk(start[s] === lvl, "frame start wait");
        if (start[s] !== lvl) summarize();
    endtask
    task automatic frame(input int s, input logic early);
        avail[s] = 1'b1;
        stored = 12'h001;
        repeat (5) @(posedge sys_clk);
        #1 chk(start[s] === early, "early start");
        comp[s] = 1'b1;
        wt(s, 1'b1);
        {done[s], avail[s], comp[s], stored} = {3'b100, 12'h0};
        @(posedge sys_clk) #1 done[s] = 1'b0;
        wt(s, 1'b0);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        {ce, chunk, cred, avail, comp, done, stored} = '0;
        ce = 1'b1;
        // Start high so the first reset edge is seen by every process
        nrst = 1'b1;
        #1;
        rst();
        foreach (rows[i]) begin
            chunk = rows[i].c;
            cred = rows[i].cr;
            host.acc(1'b1, 8'h04, rows[i].w);
            host.acc(1'b0, 8'h04, 32'h0);
            chk(reg_rvalid === 1'b1 && reg_rdata === {20'h0, rows[i].w[11:6], 6'h06}, "read back");
            chk(irq === rows[i].irq, "credit irq");
            chk(len === rows[i].len, "stamp size");
            chk(srx === rows[i].w[7] && stx === rows[i].w[7], "stamp enable");
            chk(s64 === (rows[i].w[7] & rows[i].w[6]), "stamp format");
        end
        host.acc(1'b1, 8'h05, 32'h0000_0fc0);
        host.acc(1'b0, 8'h05, 32'h0);
        chk(reg_rdata === 32'h0 && cfg === 32'h0000_0c86, "unmapped");
        ce = 1'b0;
        host.acc(1'b1, 8'h04, 32'h0);
        ce = 1'b1;
        chk(cfg === 32'h0000_0c86, "clock enable");
        chunk = 1'b1;
        host.acc(1'b1, 8'h04, 32'h0000_0300);
        frame(0, 1'b1);
        frame(1, 1'b1);
        host.acc(1'b1, 8'h04, 32'h0);
        frame(0, 1'b0);
        frame(1, 1'b0);
        host.acc(1'b1, 8'h04, 32'h0000_0fc0);
        rst();
        summarize();
    end
endmodule
